// ==== rtl/epiu_edge_detect.sv ====
`timescale 1ns/1ps
// sampled-pin edge detector for one dedicated request pin
module epiu_edge_detect (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // pin and mode
  input wire logic pinIn,
  input wire logic [1:0] sense,
  // result
  output logic setPulse,
  output logic levelLow
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } epiu_edge_s;

  epiu_edge_s st_r;
  epiu_edge_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = st_r.s2;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= 3'b111;
    end else begin
      st_r <= st_nxt;
    end
  end

  // level is taken straight from the pin so it can act with the clock stopped
  assign levelLow = ~pinIn;

  // edge modes need running samples, so they only work while the clock runs
  always_comb begin
    case (epiu_pkg::epiu_sense_e'(sense))
      epiu_pkg::SENSE_ANY: setPulse = st_r.s2 ^ st_r.prev;
      epiu_pkg::SENSE_FALL: setPulse = st_r.prev & ~st_r.s2;
      epiu_pkg::SENSE_RISE: setPulse = ~st_r.prev & st_r.s2;
      default: setPulse = 1'b0;
    endcase
  end

endmodule : epiu_edge_detect

// ==== rtl/epiu_pkg.sv ====
package epiu_pkg;

  // =====================================================================
  // register offsets on the plain register port
  // =====================================================================
  localparam logic [3:0] ADDR_SENSE = 4'h0;
  localparam logic [3:0] ADDR_EXT_MASK = 4'h1;
  localparam logic [3:0] ADDR_EXT_FLAG = 4'h2;
  localparam logic [3:0] ADDR_PC_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_PC_FLAG = 4'h4;
  localparam logic [3:0] ADDR_PC_MASK_LO = 4'h5;
  localparam logic [3:0] ADDR_PC_MASK_HI = 4'h6;
  localparam logic [3:0] ADDR_GLOBAL_EN = 4'h7;
  localparam logic [3:0] ADDR_VECTOR = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'h9;

  // =====================================================================
  // field positions and reset values
  // =====================================================================
  localparam int SENSE_A_LSB = 0;
  localparam int SENSE_B_LSB = 2;
  localparam logic [7:0] SENSE_WMASK = 8'h0f;
  localparam logic [7:0] SENSE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // =====================================================================
  // sense encodings
  // =====================================================================
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } epiu_sense_e;

  // =====================================================================
  // vector addresses, two program words apart
  // =====================================================================
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] VEC_PIN_A = 16'h0002;
  localparam logic [15:0] VEC_PIN_B = 16'h0004;
  localparam logic [15:0] VEC_PC_LO = 16'h0006;
  localparam logic [15:0] VEC_PC_HI = 16'h0008;

  // register port carrier
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epiu_bus_s;

endpackage : epiu_pkg

// ==== rtl/epiu_top.sv ====
`timescale 1ns/1ps
module epiu_top (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // pins, seen at the pad whatever the port direction
  input wire logic extRequestPinA,
  input wire logic extRequestPinB,
  input wire logic [15:0] pinChangeInputs,
  // core side
  input wire logic [3:0] isrEntry,
  output logic irq,
  output logic [15:0] irqVector,
  output logic wakeRequest,
  output logic pinChangeGroupLoRequest,
  output logic pinChangeGroupHiRequest
);

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    logic [7:0] senseCtl;
    logic [1:0] extMask;
    logic [1:0] extFlag;
    logic [1:0] pcEnable;
    logic [1:0] pcFlag;
    logic [7:0] pcMaskLo;
    logic [7:0] pcMaskHi;
    logic globalEn;
    logic [15:0] pcPrev;
    logic [7:0] rdata;
  } epiu_state_s;

  epiu_state_s st_r;
  epiu_state_s st_nxt;
  epiu_pkg::epiu_bus_s bus;

  logic setA;
  logic setB;
  logic lowA;
  logic lowB;
  logic [1:0] levelMode;
  logic [1:0] extLevelReq;
  logic [1:0] extReq;
  logic [1:0] pcToggle;
  logic [15:0] pcMaskAll;
  logic [15:0] pcDiff;
  logic [3:0] pending;

  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  function automatic logic hit(input epiu_pkg::epiu_bus_s b, input logic [3:0] a);
    hit = b.wr && (b.addr == a);
  endfunction : hit

  // =====================================================================
  // dedicated pins
  // =====================================================================
  epiu_edge_detect u_det_a (
    .mclk(mclk),
    .reset_n(reset_n),
    .pinIn(extRequestPinA),
    .sense(st_r.senseCtl[epiu_pkg::SENSE_A_LSB +: 2]),
    .setPulse(setA),
    .levelLow(lowA)
  );

  epiu_edge_detect u_det_b (
    .mclk(mclk),
    .reset_n(reset_n),
    .pinIn(extRequestPinB),
    .sense(st_r.senseCtl[epiu_pkg::SENSE_B_LSB +: 2]),
    .setPulse(setB),
    .levelLow(lowB)
  );

  assign levelMode[0] = st_r.senseCtl[epiu_pkg::SENSE_A_LSB +: 2] == epiu_pkg::SENSE_LOW;
  assign levelMode[1] = st_r.senseCtl[epiu_pkg::SENSE_B_LSB +: 2] == epiu_pkg::SENSE_LOW;
  // a short low may be missed; the source must hold it through the instruction
  assign extLevelReq = levelMode & {lowB, lowA};
  assign extReq = extLevelReq | st_r.extFlag;

  // =====================================================================
  // pin-change groups
  // =====================================================================
  // toggle compared against the last registered pin image; the comparison
  // is combinational so a toggle shows on wakeRequest with the clock off
  assign pcMaskAll = {st_r.pcMaskHi, st_r.pcMaskLo};
  generate
    for (genvar i = 0; i < 16; i++) begin : g_pc
      assign pcDiff[i] = (pinChangeInputs[i] ^ st_r.pcPrev[i]) & pcMaskAll[i];
    end
  endgenerate
  assign pcToggle[0] = |pcDiff[7:0];
  assign pcToggle[1] = |pcDiff[15:8];

  // =====================================================================
  // next state
  // =====================================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.pcPrev = pinChangeInputs;
    if (hit(bus, epiu_pkg::ADDR_SENSE)) begin
      st_nxt.senseCtl = bus.wdata & epiu_pkg::SENSE_WMASK;
    end
    if (hit(bus, epiu_pkg::ADDR_EXT_MASK)) begin
      st_nxt.extMask = bus.wdata[1:0];
    end
    if (hit(bus, epiu_pkg::ADDR_PC_ENABLE)) begin
      st_nxt.pcEnable = bus.wdata[1:0];
    end
    if (hit(bus, epiu_pkg::ADDR_PC_MASK_LO)) begin
      st_nxt.pcMaskLo = bus.wdata;
    end
    if (hit(bus, epiu_pkg::ADDR_PC_MASK_HI)) begin
      st_nxt.pcMaskHi = bus.wdata;
    end
    if (hit(bus, epiu_pkg::ADDR_GLOBAL_EN)) begin
      st_nxt.globalEn = bus.wdata[0];
    end
    // clear by write-one or routine entry; a same-cycle set wins
    if (hit(bus, epiu_pkg::ADDR_EXT_FLAG)) begin
      st_nxt.extFlag = st_nxt.extFlag & ~bus.wdata[1:0];
    end
    if (hit(bus, epiu_pkg::ADDR_PC_FLAG)) begin
      st_nxt.pcFlag = st_nxt.pcFlag & ~bus.wdata[1:0];
    end
    st_nxt.extFlag = st_nxt.extFlag & ~isrEntry[1:0];
    st_nxt.pcFlag = st_nxt.pcFlag & ~isrEntry[3:2];
    st_nxt.extFlag = st_nxt.extFlag | {setB, setA};
    st_nxt.pcFlag = st_nxt.pcFlag | pcToggle;
    st_nxt.extFlag = st_nxt.extFlag & ~levelMode;
    // read data valid only in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr == epiu_pkg::ADDR_SENSE) begin
        st_nxt.rdata = st_r.senseCtl & epiu_pkg::SENSE_WMASK;
      end else if (bus.addr == epiu_pkg::ADDR_EXT_MASK) begin
        st_nxt.rdata = {6'h00, st_r.extMask};
      end else if (bus.addr == epiu_pkg::ADDR_EXT_FLAG) begin
        st_nxt.rdata = {6'h00, st_r.extFlag & ~levelMode};
      end else if (bus.addr == epiu_pkg::ADDR_PC_ENABLE) begin
        st_nxt.rdata = {6'h00, st_r.pcEnable};
      end else if (bus.addr == epiu_pkg::ADDR_PC_FLAG) begin
        st_nxt.rdata = {6'h00, st_r.pcFlag};
      end else if (bus.addr == epiu_pkg::ADDR_PC_MASK_LO) begin
        st_nxt.rdata = st_r.pcMaskLo;
      end else if (bus.addr == epiu_pkg::ADDR_PC_MASK_HI) begin
        st_nxt.rdata = st_r.pcMaskHi;
      end else if (bus.addr == epiu_pkg::ADDR_GLOBAL_EN) begin
        st_nxt.rdata = {7'h00, st_r.globalEn};
      end else if (bus.addr == epiu_pkg::ADDR_VECTOR) begin
        st_nxt.rdata = irqVector[7:0];
      end else if (bus.addr == epiu_pkg::ADDR_STATUS) begin
        st_nxt.rdata = {2'h0, pending, extLevelReq};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{senseCtl: epiu_pkg::SENSE_RESET, extMask: 2'h0, extFlag: 2'h0,
                pcEnable: 2'h0, pcFlag: 2'h0, pcMaskLo: epiu_pkg::MASK_RESET,
                pcMaskHi: epiu_pkg::MASK_RESET, globalEn: 1'b0, pcPrev: 16'h0000,
                rdata: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // request gating and vectors
  // =====================================================================
  assign pending[1:0] = extReq & st_r.extMask & {2{st_r.globalEn}};
  assign pending[3:2] = st_r.pcFlag & st_r.pcEnable & {2{st_r.globalEn}};
  assign pinChangeGroupLoRequest = st_r.pcFlag[0];
  assign pinChangeGroupHiRequest = st_r.pcFlag[1];
  assign irq = |pending;
  // wake works off async terms; a level gone before start-up gives no irq
  assign wakeRequest = |(extLevelReq & st_r.extMask) | |(pcToggle & st_r.pcEnable);

  // lowest source wins, each vector two words above the last
  always_comb begin
    if (pending[0]) begin
      irqVector = epiu_pkg::VEC_PIN_A;
    end else if (pending[1]) begin
      irqVector = epiu_pkg::VEC_PIN_B;
    end else if (pending[2]) begin
      irqVector = epiu_pkg::VEC_PC_LO;
    end else if (pending[3]) begin
      irqVector = epiu_pkg::VEC_PC_HI;
    end else begin
      irqVector = epiu_pkg::VEC_RESET;
    end
  end

  assign regRdata = st_r.rdata;

endmodule : epiu_top

// ==== verification/epiu_chk.sv ====
`timescale 1ns/1ps
module epiu_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // pins
  input wire logic extRequestPinA,
  input wire logic extRequestPinB,
  input wire logic [15:0] pinChangeInputs,
  // core side
  input wire logic [3:0] isrEntry,
  input wire logic irq,
  input wire logic [15:0] irqVector,
  input wire logic wakeRequest,
  input wire logic pinChangeGroupLoRequest,
  input wire logic pinChangeGroupHiRequest
);
  // =====================================================================
  // shadow of the writable registers
  // =====================================================================
  logic [7:0] shd [8];
  wire lowA = shd[0][1:0] == 2'h0 && shd[1][0] && !extRequestPinA;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) shd <= '{default: 8'h00};
    else if (regWr && !regAddr[3]) shd[regAddr[2:0]] <= regWdata;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence fallA;
    shd[7][0] && shd[1][0] && shd[0][1:0] == 2'h2 ##0 $fell(extRequestPinA);
  endsequence
  sequence riseB;
    shd[7][0] && shd[1][1] && shd[0][3:2] == 2'h3 ##0 $rose(extRequestPinB);
  endsequence
  // =====================================================================
  // assertions
  // =====================================================================
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its slot");
  sense_resv_a: assert property ($past(regRd) && $past(regAddr) == 4'h0 |->
    regRdata == ($past(shd[0]) & 8'h0f)) else $error("sense readback wrong");
  level_req_a: assert property (shd[7][0] && lowA |-> irq && irqVector == 16'h0002)
    else $error("level request missing");
  level_wake_a: assert property (lowA |-> wakeRequest)
    else $error("level wake missing");
  glb_off_a: assert property (!shd[7][0] |-> !irq)
    else $error("request without global enable");
  vec_map_a: assert property ((irqVector != 0) == irq && irqVector inside {0, 2, 4, 6, 8})
    else $error("vector out of map");
  lo_set_a: assert property (|((pinChangeInputs ^ $past(pinChangeInputs)) & shd[5])
    |=> pinChangeGroupLoRequest) else $error("low group toggle lost");
  hi_set_a: assert property (|((pinChangeInputs[15:8] ^ $past(pinChangeInputs[15:8])) & shd[6])
    |=> pinChangeGroupHiRequest) else $error("high group toggle lost");
  lo_clr_a: assert property (!pinChangeGroupLoRequest || isrEntry[2]
    ##0 ((pinChangeInputs ^ $past(pinChangeInputs)) & shd[5]) == 0 |=> !pinChangeGroupLoRequest)
    else $error("low group flag wrong");
  fall_a: assert property (fallA |-> ##[3:5] irq) else $error("fall not seen");
  rise_a: assert property (riseB |-> ##[3:5] irq) else $error("rise not seen");
endmodule : epiu_chk

bind epiu_top epiu_chk i_chk (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .extRequestPinA(extRequestPinA), .extRequestPinB(extRequestPinB),
  .pinChangeInputs(pinChangeInputs), .isrEntry(isrEntry), .irq(irq), .irqVector(irqVector),
  .wakeRequest(wakeRequest), .pinChangeGroupLoRequest(pinChangeGroupLoRequest),
  .pinChangeGroupHiRequest(pinChangeGroupHiRequest));

// ==== verification/epiu_core_model.sv ====
`timescale 1ns/1ps
module epiu_core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // from the block, plus the acknowledge enable from the testbench
  input wire logic irq,
  input wire logic [15:0] irqVector,
  input wire logic ackEn,
  // routine entry
  output logic [3:0] isrEntry
);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      isrEntry <= 4'h0;
    end else begin
      // gap after each pulse so the next vector is read once the flag dropped
      isrEntry <= 4'h0;
      if (ackEn && irq && isrEntry == 4'h0) begin
        isrEntry <= 4'h1 << (irqVector[3:1] - 3'h1);
      end
    end
  end
endmodule : epiu_core_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic pinA = 1'b1;
  logic pinB = 1'b1;
  logic [15:0] pcIn = 16'h0000;
  logic ackEn = 1'b0;
  logic [7:0] regRdata, rv;
  logic [3:0] isrEntry;
  logic irq, wake, pcLo, pcHi;
  logic [15:0] irqVector;
  logic [5:0] row;
  int nFail = 0;
  int totalChecks = 0;
  // sel, sense, start level, end level, request expected
  localparam logic [5:0] ROWS [10] = '{6'h05, 6'h0d, 6'h15, 6'h1c, 6'h1b, 6'h0b, 6'h12,
    6'h25, 6'h35, 6'h3b};
  always #4 mclk = ~mclk;
  epiu_top i_dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extRequestPinA(pinA),
    .extRequestPinB(pinB), .pinChangeInputs(pcIn), .isrEntry(isrEntry), .irq(irq),
    .irqVector(irqVector), .wakeRequest(wake), .pinChangeGroupLoRequest(pcLo),
    .pinChangeGroupHiRequest(pcHi));
  epiu_core_model i_core (.mclk(mclk), .reset_n(reset_n), .irq(irq), .irqVector(irqVector),
    .ackEn(ackEn), .isrEntry(isrEntry));
  // =====================================================================
  // tasks
  // =====================================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask : rd
  task automatic testDone;
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : testDone
  // =====================================================================
  // sequence
  // =====================================================================
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0]);
      chk("reset value", 16'h0000, {8'h00, rv});
    end
    wr(epiu_pkg::ADDR_SENSE, 8'hff);
    rd(epiu_pkg::ADDR_SENSE);
    chk("sense", 16'h000f, {8'h00, rv});
    wr(4'hf, 8'hff);
    rd(4'hf);
    chk("unmapped", 16'h0000, {8'h00, rv});
    wr(epiu_pkg::ADDR_EXT_MASK, 8'h03);
    wr(epiu_pkg::ADDR_GLOBAL_EN, 8'h01);
    foreach (ROWS[i]) begin
      row = ROWS[i];
      pinA <= row[5] | row[2];
      pinB <= !row[5] | row[2];
      tick(6);
      wr(epiu_pkg::ADDR_SENSE, row[5] ? {4'h0, row[4:3], 2'h0} : {6'h00, row[4:3]});
      wr(epiu_pkg::ADDR_EXT_FLAG, 8'h03);
      if (row[5]) pinB <= row[1];
      else pinA <= row[1];
      tick(6);
      chk("vector", row[0] ? {13'h0, row[5], !row[5], 1'b0} : 16'h0, irqVector);
      rd(epiu_pkg::ADDR_EXT_FLAG);
      chk("flag", {15'h0, row[0] & (row[4:3] != 2'h0)}, {15'h0, rv[row[5]]});
    end
    // the last row leaves the second pin's flag set; clear it so the group vectors show
    wr(epiu_pkg::ADDR_EXT_FLAG, 8'h03);
    wr(epiu_pkg::ADDR_PC_ENABLE, 8'h03);
    wr(epiu_pkg::ADDR_PC_MASK_LO, 8'h01);
    wr(epiu_pkg::ADDR_PC_MASK_HI, 8'h80);
    pcIn <= 16'h0002;
    tick(3);
    chk("masked pin", 16'h0000, irqVector);
    chk("masked flags", 16'h0000, {14'h0, pcHi, pcLo});
    pcIn <= 16'h8003;
    tick(3);
    chk("group vector", epiu_pkg::VEC_PC_LO, irqVector);
    chk("group flags", 16'h0003, {14'h0, pcHi, pcLo});
    wr(epiu_pkg::ADDR_PC_FLAG, 8'h02);
    rd(epiu_pkg::ADDR_PC_FLAG);
    chk("write one", 16'h0001, {8'h00, rv});
    ackEn <= 1'b1;
    tick(4);
    ackEn <= 1'b0;
    chk("entry clear", 16'h0000, {15'h0, irq});
    wr(epiu_pkg::ADDR_GLOBAL_EN, 8'h00);
    // held low well past any instruction boundary
    pinA <= 1'b0;
    tick(2);
    chk("global off", 16'h0000, {15'h0, irq});
    chk("wake", 16'h0001, {15'h0, wake});
    wr(epiu_pkg::ADDR_GLOBAL_EN, 8'h01);
    pcIn <= 16'h8002;
    tick(3);
    chk("priority", epiu_pkg::VEC_PIN_A, irqVector);
    rd(epiu_pkg::ADDR_VECTOR);
    chk("vector read", epiu_pkg::VEC_PIN_A, {8'h00, rv});
    // pending = lo group and pin a, level request = pin a
    rd(epiu_pkg::ADDR_STATUS);
    chk("status read", 16'h0015, {8'h00, rv});
    pinA <= 1'b1;
    // reset in mid-run with a group flag set and all registers written
    reset_n <= 1'b0;
    tick(2);
    chk("reset flags", 16'h0000, {14'h0, pcHi, pcLo});
    chk("reset irq", 16'h0000, {15'h0, irq});
    reset_n <= 1'b1;
    rd(epiu_pkg::ADDR_PC_MASK_LO);
    chk("reset mask", 16'h0000, {8'h00, rv});
    tick(2);
    chk("reset vector", 16'h0000, irqVector);
    testDone();
  end
endmodule : tb_top
